/* verilog/clock_top_consts.svh */
// Purpose: offsets, field positions and reset values of the clock control bank
// Assumes: 32-bit APB, byte addresses equal printed offsets
// Notes: included by the top module only
`ifndef CLOCK_TOP_CONSTS_SVH
`define CLOCK_TOP_CONSTS_SVH
`define OFS_CPU_PLL_CTL 8'h44
`define OFS_PWM4 8'h4c
`define OFS_PWM5 8'h50
`define OFS_IOC_DELAY 8'h5c
`define OFS_BIU_GATE 8'h68
`define OFS_CPU_PLL_CTL3 8'h70
`define OFS_CPU_PLL_CTL2 8'h98
`define OFS_PWM1 8'hb0
`define OFS_PWM2 8'hb4
`define OFS_TEST_CLK 8'hb8
`define OFS_THERM_EN 8'hc0
`define OFS_THERM_FLAG 8'hc4
`define OFS_THERM_WIN 8'hc8
`define OFS_PWM3 8'hcc
`define OFS_PLL_SPARE 8'hd0
`define OFS_MISC_B 8'he4
`define OFS_MISC_C 8'he8
`define OFS_MISC_STATUS 8'hec
`define OFS_LINK_GATE 8'hf8
`define OFS_IRQ_STATUS 8'hf0
`define OFS_IRQ_MASK 8'hf4
`define RST_IOC_DELAY 32'h0000_0042
`define RST_BIU_GATE 32'h0003_109f
`define RST_CPU_PLL_CTL3 32'h0200_0001
`define RST_CPU_PLL_CTL2 32'h0000_0040
`define RST_LINK_GATE 32'h0000_0fff
`define BIT_MCLK_STOP 0
`define BIT_SEQA_GATE 1
`define BIT_SEQB_GATE 2
`define BIT_VBLANK_SEL 14
`define BIT_VBLANK_SYNC 15
`define BIT_CAL_OVERRIDE 16
`define BIT_CP_MIRROR_SEL 25
`define BIT_REF_SEL 0
`define PWM_EN_BIT 24
`define PWM_OE_BIT 25
`define PWM3_EN_BIT 0
`define CTL2_RW_MASK 32'h001f_ffff
`define NUM_PWM 5
`endif

/* verilog/clock_top_pkg.sv */
// Purpose: types shared by the clock control bank
// Assumes: constants come from clock_top_consts.svh
// Notes: none
`default_nettype none
package clock_top_pkg;
  typedef struct packed {
    logic [11:0] period;
    logic [11:0] high;
    logic en;
    logic oe;
  } pwm_cfg_type;
  typedef struct packed {
    logic [2:0] refFreq;
    logic [1:0] fwdDiv;
    logic [1:0] vcoMode;
    logic [3:0] chargePump;
  } pll_rb_type;
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_WAIT = 2'b01,
    SW_DONE = 2'b11
  } switch_state_type;
endpackage
`default_nettype wire

/* verilog/clock_top_misc_control.sv */
// Purpose: clock configuration register bank with pwm, gating and pll control
// Assumes: APB slave, single clock ref_clk at 250 MHz, async active-low reset
// Notes: pad input is synchronised by three flip-flops, pll readback inputs by two
//
// Notes on behaviour
// - misc b bit 0 set stops the always-running memory clock branch.
// - misc b bits 1 and 2 drop extra gating for sequencer A and B.
// - misc b bits 3 to 5 are scratch storage only.
// - misc b bit 14 picks primary or secondary display vertical blank.
// - misc b bit 15 makes memory clock switching wait for vertical blank.
// - pll control bit 16 picks loop or register bits 15:12 for calibration.
// - control two bits 28:27 read back the forward divider ratio.
// - control two bits 31:29 read back the detected reference frequency.
// - control two bits 24:21 and 26:25 read back charge pump and vco mode.
// - control three bit 25 picks manual or calibrated charge pump mirror.
// - reference select at reset value picks the 100MHz pcie reference.
// - status bit 0 returns oscillator pad level, bits 31:1 read zero.
`timescale 1ns/1ps
`default_nettype none
`include "clock_top_consts.svh"
module clock_top_misc_control (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscPadLevelIn,
  input wire logic thermalAlertIn,
  input wire logic vblankPrimaryIn,
  input wire logic vblankSecondaryIn,
  input wire logic mclkSwitchReq,
  input wire logic [3:0] calLoopBits,
  input wire logic [3:0] cpCalBits,
  input wire logic [10:0] pllReadbackIn,
  output logic mclkSwitchGo,
  output logic permMclkStop,
  output logic seqAExtraGateOff,
  output logic seqBExtraGateOff,
  output logic cpuPllRefPcie,
  output logic [3:0] cpuPllCalBits,
  output logic cpMirrorCal,
  output logic [3:0] cpMirrorBits,
  output logic [2:0] skew4x,
  output logic [2:0] skew2x,
  output logic [4:0] pwmOut,
  output logic [4:0] pwmOutEn_n,
  output logic irq
);
  // ==========================================================
  // synchronisers
  logic [2:0] syncA_q;
  logic [2:0] syncB_q;
  logic [9:0] rbSyncA_q;
  logic [9:0] rbSyncB_q;
  logic oscSync_q;
  logic alertPrev_q;
  logic vbPrev_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q <= 3'h0;
      syncB_q <= 3'h0;
      rbSyncA_q <= 10'h000;
      rbSyncB_q <= 10'h000;
      oscSync_q <= 1'b0;
    end else begin
      syncA_q <= {vblankSecondaryIn, vblankPrimaryIn, thermalAlertIn};
      syncB_q <= syncA_q;
      rbSyncA_q <= pllReadbackIn[10:1];
      rbSyncB_q <= rbSyncA_q;
      oscSync_q <= oscPadLevelIn;
    end
  end
  logic oscPadA_q;
  logic oscPadB_q;
  logic pllLsbA_q;
  logic pllLsbB_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      oscPadA_q <= 1'b0;
      oscPadB_q <= 1'b0;
      pllLsbA_q <= 1'b0;
      pllLsbB_q <= 1'b0;
    end else begin
      oscPadA_q <= oscSync_q;
      oscPadB_q <= oscPadA_q;
      pllLsbA_q <= pllReadbackIn[0];
      pllLsbB_q <= pllLsbA_q;
    end
  end
  wire clock_top_pkg::pll_rb_type pllRb = {rbSyncB_q, pllLsbB_q};
  wire alertLvl = syncB_q[0];

  // ==========================================================
  // register storage
  logic [31:0] pllCtl_q;
  logic [31:0] pwm4_q;
  logic [31:0] pwm5_q;
  logic [31:0] iocDelay_q;
  logic [31:0] biuGate_q;
  logic [31:0] pllCtl3_q;
  logic [31:0] pllCtl2_q;
  logic [31:0] pwm1_q;
  logic [31:0] pwm2_q;
  logic [31:0] testClk_q;
  logic [31:0] thermEn_q;
  logic [31:0] thermWin_q;
  logic [31:0] pwm3_q;
  logic [31:0] pllSpare_q;
  logic [31:0] miscB_q;
  logic [31:0] miscC_q;
  logic [31:0] linkGate_q;
  logic thermFlag_q;
  logic irqMask_q;
  wire wrEn = psel & penable & pwrite;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction
  wire alertRise = alertLvl & ~alertPrev_q;
  wire flagClr = wrEn & (hit(paddr, `OFS_THERM_FLAG) | hit(paddr, `OFS_IRQ_STATUS)) & pwdata[0];
  // per-register write strobes
  wire wrPllCtl = wrEn & hit(paddr, `OFS_CPU_PLL_CTL);
  wire wrPwm4 = wrEn & hit(paddr, `OFS_PWM4);
  wire wrPwm5 = wrEn & hit(paddr, `OFS_PWM5);
  wire wrIocDelay = wrEn & hit(paddr, `OFS_IOC_DELAY);
  wire wrBiuGate = wrEn & hit(paddr, `OFS_BIU_GATE);
  wire wrPllCtl3 = wrEn & hit(paddr, `OFS_CPU_PLL_CTL3);
  wire wrPllCtl2 = wrEn & hit(paddr, `OFS_CPU_PLL_CTL2);
  wire wrPwm1 = wrEn & hit(paddr, `OFS_PWM1);
  wire wrPwm2 = wrEn & hit(paddr, `OFS_PWM2);
  wire wrTestClk = wrEn & hit(paddr, `OFS_TEST_CLK);
  wire wrThermEn = wrEn & hit(paddr, `OFS_THERM_EN);
  wire wrThermWin = wrEn & hit(paddr, `OFS_THERM_WIN);
  wire wrPwm3 = wrEn & hit(paddr, `OFS_PWM3);
  wire wrPllSpare = wrEn & hit(paddr, `OFS_PLL_SPARE);
  wire wrMiscB = wrEn & hit(paddr, `OFS_MISC_B);
  wire wrMiscC = wrEn & hit(paddr, `OFS_MISC_C);
  wire wrLinkGate = wrEn & hit(paddr, `OFS_LINK_GATE);
  wire wrIrqMask = wrEn & hit(paddr, `OFS_IRQ_MASK);
  // next values, reserved bits kept at zero
  wire [31:0] pllCtl_d = wrPllCtl ? {4'h0, pwdata[27:0]} : pllCtl_q;
  wire [31:0] pwm4_d = wrPwm4 ? {6'h0, pwdata[25:0]} : pwm4_q;
  wire [31:0] pwm5_d = wrPwm5 ? {6'h0, pwdata[25:0]} : pwm5_q;
  wire [31:0] iocDelay_d = wrIocDelay ? {22'h0, pwdata[9:0]} : iocDelay_q;
  wire [31:0] biuGate_d = wrBiuGate ? {14'h0, pwdata[17:0]} : biuGate_q;
  wire [31:0] pllCtl3_d = wrPllCtl3 ? pwdata : pllCtl3_q;
  wire [31:0] pllCtl2_d = wrPllCtl2 ? (pwdata & `CTL2_RW_MASK) : pllCtl2_q;
  wire [31:0] pwm1_d = wrPwm1 ? {6'h0, pwdata[25:0]} : pwm1_q;
  wire [31:0] pwm2_d = wrPwm2 ? {6'h0, pwdata[25:0]} : pwm2_q;
  wire [31:0] testClk_d = wrTestClk ? {pwdata[31:16], 8'h0, pwdata[7:0]} : testClk_q;
  wire [31:0] thermEn_d = wrThermEn ? pwdata : thermEn_q;
  wire [31:0] thermWin_d = wrThermWin ? pwdata : thermWin_q;
  wire [31:0] pwm3_d = wrPwm3 ? {6'h0, pwdata[25:0]} : pwm3_q;
  wire [31:0] pllSpare_d = wrPllSpare ? pwdata : pllSpare_q;
  wire [31:0] miscB_d = wrMiscB ? pwdata : miscB_q;
  wire [31:0] miscC_d = wrMiscC ? pwdata : miscC_q;
  wire [31:0] linkGate_d = wrLinkGate ? {18'h0, pwdata[13:0]} : linkGate_q;
  wire irqMask_d = wrIrqMask ? pwdata[0] : irqMask_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pllCtl_q <= 32'h0;
      pwm4_q <= 32'h0;
      pwm5_q <= 32'h0;
      iocDelay_q <= `RST_IOC_DELAY;
      biuGate_q <= `RST_BIU_GATE;
      pllCtl3_q <= `RST_CPU_PLL_CTL3;
      pllCtl2_q <= `RST_CPU_PLL_CTL2;
      pwm1_q <= 32'h0;
      pwm2_q <= 32'h0;
      testClk_q <= 32'h0;
      thermEn_q <= 32'h0;
      thermWin_q <= 32'h0;
      pwm3_q <= 32'h0;
      pllSpare_q <= 32'h0;
      miscB_q <= 32'h0;
      miscC_q <= 32'h0;
      linkGate_q <= `RST_LINK_GATE;
      irqMask_q <= 1'b0;
      alertPrev_q <= 1'b0;
    end else begin
      alertPrev_q <= alertLvl;
      pllCtl_q <= pllCtl_d;
      pwm4_q <= pwm4_d;
      pwm5_q <= pwm5_d;
      iocDelay_q <= iocDelay_d;
      biuGate_q <= biuGate_d;
      pllCtl3_q <= pllCtl3_d;
      pllCtl2_q <= pllCtl2_d;
      pwm1_q <= pwm1_d;
      pwm2_q <= pwm2_d;
      testClk_q <= testClk_d;
      thermEn_q <= thermEn_d;
      thermWin_q <= thermWin_d;
      pwm3_q <= pwm3_d;
      pllSpare_q <= pllSpare_d;
      miscB_q <= miscB_d;
      miscC_q <= miscC_d;
      linkGate_q <= linkGate_d;
      irqMask_q <= irqMask_d;
    end
  end
  // flag: hardware set wins over write-one clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      thermFlag_q <= 1'b0;
    end else begin
      thermFlag_q <= alertRise | (thermFlag_q & ~flagClr);
    end
  end

  // ==========================================================
  // read path
  wire [31:0] ctl2Read = {pllRb.refFreq, pllRb.fwdDiv,
    pllRb.vcoMode, pllRb.chargePump, pllCtl2_q[20:0]};
  logic [31:0] rdMux;
  logic rdHit;
  always_comb begin
    rdHit = 1'b1;
    case (paddr)
      `OFS_CPU_PLL_CTL: rdMux = pllCtl_q;
      `OFS_PWM4: rdMux = pwm4_q;
      `OFS_PWM5: rdMux = pwm5_q;
      `OFS_IOC_DELAY: rdMux = iocDelay_q;
      `OFS_BIU_GATE: rdMux = biuGate_q;
      `OFS_CPU_PLL_CTL3: rdMux = pllCtl3_q;
      `OFS_CPU_PLL_CTL2: rdMux = ctl2Read;
      `OFS_PWM1: rdMux = pwm1_q;
      `OFS_PWM2: rdMux = pwm2_q;
      `OFS_TEST_CLK: rdMux = testClk_q;
      `OFS_THERM_EN: rdMux = thermEn_q;
      `OFS_THERM_FLAG: rdMux = {31'h0, thermFlag_q};
      `OFS_THERM_WIN: rdMux = thermWin_q;
      `OFS_PWM3: rdMux = pwm3_q;
      `OFS_PLL_SPARE: rdMux = pllSpare_q;
      `OFS_MISC_B: rdMux = miscB_q;
      `OFS_MISC_C: rdMux = miscC_q;
      `OFS_MISC_STATUS: rdMux = {31'h0, oscPadB_q};
      `OFS_LINK_GATE: rdMux = linkGate_q;
      `OFS_IRQ_STATUS: rdMux = {31'h0, thermFlag_q};
      `OFS_IRQ_MASK: rdMux = {31'h0, irqMask_q};
      default: begin
        rdMux = 32'h0;
        rdHit = 1'b0;
      end
    endcase
  end
  wire setup = psel & ~penable;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~rdHit;
      if (setup & ~pwrite) begin
        prdata <= rdMux;
      end
    end
  end

  // ==========================================================
  // memory clock switching on vertical blank
  wire vbPrim = syncB_q[1];
  wire vbSec = syncB_q[2];
  wire vbSel = miscB_q[`BIT_VBLANK_SEL] ? vbSec : vbPrim;
  wire vbRise = vbSel & ~vbPrev_q;
  clock_top_pkg::switch_state_type sw_q, sw_d;
  always_comb begin
    case (sw_q)
      clock_top_pkg::SW_IDLE: begin
        if (!mclkSwitchReq) sw_d = clock_top_pkg::SW_IDLE;
        else if (miscB_q[`BIT_VBLANK_SYNC]) sw_d = clock_top_pkg::SW_WAIT;
        else sw_d = clock_top_pkg::SW_DONE;
      end
      clock_top_pkg::SW_WAIT: begin
        if (!mclkSwitchReq) sw_d = clock_top_pkg::SW_IDLE;
        else if (vbRise) sw_d = clock_top_pkg::SW_DONE;
        else sw_d = clock_top_pkg::SW_WAIT;
      end
      clock_top_pkg::SW_DONE: sw_d = clock_top_pkg::SW_IDLE;
      default: sw_d = clock_top_pkg::SW_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_q <= clock_top_pkg::SW_IDLE;
      vbPrev_q <= 1'b0;
      mclkSwitchGo <= 1'b0;
    end else begin
      sw_q <= sw_d;
      vbPrev_q <= vbSel;
      mclkSwitchGo <= (sw_d == clock_top_pkg::SW_DONE);
    end
  end

  // ==========================================================
  // pwm channels
  clock_top_pkg::pwm_cfg_type pwmCfg [`NUM_PWM];
  assign pwmCfg[0] = {pwm1_q[11:0], pwm1_q[23:12], pwm1_q[`PWM_EN_BIT], pwm1_q[`PWM_OE_BIT]};
  assign pwmCfg[1] = {pwm2_q[11:0], pwm2_q[23:12], pwm2_q[`PWM_EN_BIT], pwm2_q[`PWM_OE_BIT]};
  assign pwmCfg[2] = {pwm3_q[12:1], pwm3_q[24:13], pwm3_q[`PWM3_EN_BIT], pwm3_q[`PWM_OE_BIT]};
  assign pwmCfg[3] = {pwm4_q[11:0], pwm4_q[23:12], pwm4_q[`PWM_EN_BIT], pwm4_q[`PWM_OE_BIT]};
  assign pwmCfg[4] = {pwm5_q[11:0], pwm5_q[23:12], pwm5_q[`PWM_EN_BIT], pwm5_q[`PWM_OE_BIT]};
  logic [11:0] pwmCnt_q [`NUM_PWM];
  genvar g;
  generate
    for (g = 0; g < `NUM_PWM; g++) begin : g_pwm
      wire [11:0] cntNext = pwmCnt_q[g] + 12'h001;
      wire wrap = (cntNext >= pwmCfg[g].period);
      wire dutyHigh = pwmCfg[g].en & (pwmCnt_q[g] < pwmCfg[g].high);
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          pwmCnt_q[g] <= 12'h000;
          pwmOut[g] <= 1'b0;
          pwmOutEn_n[g] <= 1'b1;
        end else begin
          pwmCnt_q[g] <= (!pwmCfg[g].en || wrap) ? 12'h000 : cntNext;
          pwmOut[g] <= dutyHigh;
          pwmOutEn_n[g] <= ~pwmCfg[g].oe;
        end
      end
    end
  endgenerate

  // ==========================================================
  // memory clock gating outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      permMclkStop <= 1'b0;
      seqAExtraGateOff <= 1'b0;
      seqBExtraGateOff <= 1'b0;
    end else begin
      permMclkStop <= miscB_q[`BIT_MCLK_STOP];
      seqAExtraGateOff <= miscB_q[`BIT_SEQA_GATE];
      seqBExtraGateOff <= miscB_q[`BIT_SEQB_GATE];
    end
  end

  // ==========================================================
  // pll control outputs
  wire [3:0] cpManualBits = {pllCtl3_q[6:5], pllCtl3_q[4:3]};
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpuPllRefPcie <= 1'b1;
      cpuPllCalBits <= 4'h0;
      cpMirrorCal <= 1'b1;
      cpMirrorBits <= 4'h0;
      skew4x <= 3'h0;
      skew2x <= 3'h0;
    end else begin
      cpuPllRefPcie <= ~pllCtl_q[`BIT_REF_SEL];
      cpuPllCalBits <= pllCtl_q[`BIT_CAL_OVERRIDE] ? pllCtl_q[15:12] : calLoopBits;
      cpMirrorCal <= pllCtl3_q[`BIT_CP_MIRROR_SEL];
      cpMirrorBits <= pllCtl3_q[`BIT_CP_MIRROR_SEL] ? cpCalBits : cpManualBits;
      skew4x <= pllCtl_q[5:3];
      skew2x <= pllCtl_q[8:6];
    end
  end

  // ==========================================================
  // interrupt
  wire irqPending = thermFlag_q & thermEn_q[0] & irqMask_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irqPending;
    end
  end
endmodule // clock_top_misc_control
`default_nettype wire

/* test/clock_top_misc_control_assertions.sv */
// Purpose: port checks of the clock control bank
// Assumes: apb access phase of one cycle
// Notes: bound from the test top
`timescale 1ns/1ps
`default_nettype none
module clock_top_misc_control_assertions (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mclkSwitchReq,
  input wire logic mclkSwitchGo,
  input wire logic permMclkStop,
  input wire logic seqAExtraGateOff,
  input wire logic seqBExtraGateOff,
  input wire logic cpuPllRefPcie,
  input wire logic [2:0] skew4x,
  input wire logic [2:0] skew2x,
  input wire logic [4:0] pwmOutEn_n
);
  // ==========
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence wr_at(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_refused_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_gate_apply: assert property (wr_at(8'he4) |-> ##2
    {seqBExtraGateOff, seqAExtraGateOff, permMclkStop} == $past(pwdata[2:0], 2))
    else $error("gate outputs wrong");
  a_skew_apply: assert property (wr_at(8'h44) |-> ##2 skew4x == $past(pwdata[5:3], 2)
    && skew2x == $past(pwdata[8:6], 2) && cpuPllRefPcie == !$past(pwdata[0], 2))
    else $error("pll control outputs wrong");
  a_pwm_drive: assert property (wr_at(8'hb0) |-> ##2
    pwmOutEn_n[0] == !$past(pwdata[25], 2))
    else $error("pwm drive enable wrong");
  a_status_res: assert property (pready && !pwrite && paddr == 8'hec |->
    prdata[31:1] == 31'h0)
    else $error("status reserved bits set");
  a_go_cause: assert property ($rose(mclkSwitchGo) |-> $past(mclkSwitchReq))
    else $error("switch without request");
  a_go_pulse: assert property (mclkSwitchGo |=> !mclkSwitchGo)
    else $error("switch pulse too long");
endmodule // clock_top_misc_control_assertions
`default_nettype wire

/* test/pll_side_model.sv */
// Purpose: static stand-in for the cpu pll and its calibration loop
// Assumes: analog values hold still during a run
// Notes: readback packs ref freq, divider, vco mode, charge pump
`timescale 1ns/1ps
`default_nettype none
module pll_side_model #(
  parameter logic [10:0] READBACK = 11'h5a9,
  parameter logic [3:0] LOOP_CAL = 4'h6,
  parameter logic [3:0] MIRROR_CAL = 4'h9
) (
  output logic [10:0] pllReadbackIn,
  output logic [3:0] calLoopBits,
  output logic [3:0] cpCalBits
);
  // ==========
  // pll state
  assign pllReadbackIn = READBACK;
  assign calLoopBits = LOOP_CAL;
  assign cpCalBits = MIRROR_CAL;
endmodule // pll_side_model
`default_nettype wire

/* test/clock_top_misc_control_test.sv */
// Purpose: register-level test of the clock control bank
// Assumes: apb master tasks, one 250 MHz clock
// Notes: pll side is a static model
`timescale 1ns/1ps
`default_nettype none
module clock_top_misc_control_test;
  localparam logic [10:0] RB = 11'h5a9;
  logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, errSeen;
  logic oscPadLevelIn, thermalAlertIn, vblankPrimaryIn, vblankSecondaryIn;
  logic mclkSwitchReq, mclkSwitchGo, permMclkStop, seqAExtraGateOff, seqBExtraGateOff;
  logic cpuPllRefPcie, cpMirrorCal;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [10:0] pllReadbackIn;
  logic [3:0] calLoopBits, cpCalBits, cpuPllCalBits, cpMirrorBits;
  logic [2:0] skew4x, skew2x;
  logic [4:0] pwmOut, pwmOutEn_n;
  logic [7:0] pwmAddr [5] = '{8'hb0, 8'hb4, 8'hcc, 8'h4c, 8'h50};
  int errors = 0, total_checks = 0, goCnt = 0, hi;
  pll_side_model #(.READBACK(RB), .LOOP_CAL(4'h6), .MIRROR_CAL(4'h9)) u_pll (.*);
  clock_top_misc_control u_dut (.*);
  // ==========
  // clock and tasks
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    if (mclkSwitchGo === 1'b1) goCnt++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      end_of_test;
    end
    rdat = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic blank(input logic sec);
    if (sec) vblankSecondaryIn <= 1'b1;
    else vblankPrimaryIn <= 1'b1;
    cyc(4);
    vblankPrimaryIn <= 1'b0;
    vblankSecondaryIn <= 1'b0;
    cyc(8);
  endtask
  // ==========
  // sequence
  initial begin
    {reset_n, psel, penable, pwrite, oscPadLevelIn, thermalAlertIn} = '0;
    {vblankPrimaryIn, vblankSecondaryIn, mclkSwitchReq, paddr, pwdata} = '0;
    cyc(12);
    chk(32'({cpuPllRefPcie, cpMirrorCal, pwmOutEn_n, irq}), 32'hfe);
    reset_n <= 1'b1;
    rd(8'h5c, 32'h42);
    rd(8'h68, 32'h3109f);
    rd(8'h70, 32'h0200_0001);
    rd(8'h98, {RB, 21'h40});
    rd(8'hf8, 32'hfff);
    wr(8'he4, 32'h3f);
    cyc(2);
    chk(32'({permMclkStop, seqAExtraGateOff, seqBExtraGateOff}), 32'h7);
    rd(8'he4, 32'h3f);
    wr(8'he4, 32'h1a);
    cyc(2);
    chk(32'({permMclkStop, seqAExtraGateOff, seqBExtraGateOff}), 32'h2);
    for (int s = 0; s < 3; s++) begin
      wr(8'he4, s == 0 ? 32'h0 : (s == 1 ? 32'hc000 : 32'h8000));
      hi = goCnt;
      mclkSwitchReq <= 1'b1;
      if (s > 0) begin
        blank(s == 2);
        chk(goCnt - hi, 0);
        blank(s == 1);
      end
      for (int n = 0; n < 40 && goCnt == hi; n++) cyc(1);
      mclkSwitchReq <= 1'b0;
      cyc(4);
      chk(goCnt - hi, 1);
    end
    wr(8'h44, 32'h0001_a1e9);
    cyc(2);
    chk(32'({cpuPllCalBits, skew2x, skew4x, cpuPllRefPcie}), 32'h57a);
    rd(8'h44, 32'h0001_a1e9);
    wr(8'h44, 32'h0);
    cyc(2);
    chk(32'({cpuPllCalBits, cpuPllRefPcie}), 32'hd);
    wr(8'h70, 32'h58);
    cyc(2);
    chk(32'({cpMirrorCal, cpMirrorBits}), 32'hb);
    wr(8'h70, 32'h0200_0058);
    cyc(2);
    chk(32'({cpMirrorCal, cpMirrorBits}), 32'h19);
    wr(8'h98, 32'hffff_ffff);
    rd(8'h98, {RB, 21'h1f_ffff});
    for (int i = 0; i < 5; i++) begin
      wr(pwmAddr[i], i == 2 ? 32'h0200_400b : 32'h0300_2005);
      cyc(12);
      hi = 0;
      repeat (10) begin
        @(negedge ref_clk);
        hi += pwmOut[i];
      end
      chk(hi, 4);
      chk(32'(pwmOutEn_n), 32'h1f & (32'h1f << (i + 1)));
    end
    wr(8'hb0, 32'h0100_2005);
    cyc(2);
    chk(32'(pwmOutEn_n[0]), 32'h1);
    wr(8'hc0, 32'h1);
    wr(8'hf4, 32'h1);
    for (int m = 0; m < 2; m++) begin
      thermalAlertIn <= 1'b1;
      cyc(8);
      thermalAlertIn <= 1'b0;
      chk(32'(irq), 32'(m == 0));
      rd(8'hc4, 32'h1);
      wr(m == 0 ? 8'hf0 : 8'hc4, 32'h1);
      cyc(2);
      chk(32'(irq), 32'h0);
      rd(8'hf0, 32'h0);
      wr(8'hc0, 32'h0);
    end
    oscPadLevelIn <= 1'b1;
    wr(8'hec, 32'hffff_fffe);
    rd(8'hec, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h0);
    chk(32'(errSeen), 32'h1);
    wr(8'hd0, 32'ha5c3_0f96);
    rd(8'hd0, 32'ha5c3_0f96);
    end_of_test;
  end
endmodule // clock_top_misc_control_test
bind clock_top_misc_control clock_top_misc_control_assertions u_chk (.*);
`default_nettype wire
